// [verilog/brc_pkg.sv]
// ----------------------------------------------------------------------------
// Notes on behaviour
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Regulator stays off while the enable pin is low; otherwise the bit-7 enable decides.
// - Each voltage register holds a read-write seven-bit code in bits 6:0.
// - Target voltage is 0.600 V plus code times 6.25 mV.
// - Select pin low uses the first voltage register; high uses the second.
// - Control bit 7 set discharges the output whenever the regulator is disabled.
// - Control bits 6:4 pick the ramp rate for rising transitions only; all codes valid.
// - Slew code 000 is 64 mV/us, each step halves, 111 is 0.5 mV/us.
// - Control bit 3 and first identity bit 4 always read zero.
// - Writing 1 to control bit 2 restores both voltage registers and the control register; bit reads zero.
// - Mode bit 0 (pin low) or bit 1 (pin high) selects forced PWM.
// - First identity register is read-only: maker code 7:5, chip type 3:0.
// - Second identity register is read-only: zeros in 7:4, revision in 3:0.
// - Monitor bit 7 is set only when enabled and soft-start finished.
// - Monitor bit 6 shows input below the lockout threshold.
// - Monitor bit 5 shows input above the overvoltage threshold.
// - Monitor bit 4 stays set during a rising change until target reached.
// - Monitor bit 3 stays set during a falling change until target reached.
// - Monitor bit 2 sets after a register reset; reading register 5 clears it.
// - Host reaches registers through the serial slave port, most significant bit first.
package brc_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_VSET_LOW = 8'h00;
  localparam logic [7:0] ADDR_VSET_HIGH = 8'h01;
  localparam logic [7:0] ADDR_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_ID_VENDOR = 8'h03;
  localparam logic [7:0] ADDR_ID_REV = 8'h04;
  localparam logic [7:0] ADDR_MONITOR = 8'h05;

  // --------------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------------
  localparam int VSET_EN_BIT = 7;
  localparam logic [7:0] VSET_RESET = 8'hC0; // Enable set, code arbitrary default 0x40
  localparam int CTRL_DISCH_BIT = 7;
  localparam int CTRL_SLEW_LSB = 4;
  localparam int CTRL_RESET_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h82;
  localparam logic [7:0] CTRL_WMASK = 8'hF3; // Bits 3 and 2 never stored
  localparam logic [2:0] VENDOR_CODE = 3'h5; // Arbitrary value
  localparam logic [3:0] CHIP_TYPE = 4'h3; // Arbitrary value
  localparam logic [3:0] SILICON_REV = 4'h2; // Arbitrary value

  // --------------------------------------------------------------------------
  // Voltage scale, microvolts
  // --------------------------------------------------------------------------
  localparam int VOUT_BASE_UV = 600000;
  localparam int VOUT_STEP_UV = 6250;
  localparam int SLEW_FAST_UV_PER_US = 64000;

  // --------------------------------------------------------------------------
  // Serial port addressing
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_OFFSET = 8'h00;

  // Analog status from the converter
  typedef struct packed {
    logic soft_start_done;
    logic input_low_lockout_flag;
    logic input_overvoltage_flag;
    logic rising_transition_busy;
    logic falling_transition_busy;
    logic thermal_trip_flag;
    logic converter_active;
  } brc_status_t;

  // Settings toward the converter
  typedef struct packed {
    logic regulator_on;
    logic discharge_on;
    logic forced_pwm;
    logic [6:0] voltage_code;
    logic [2:0] slew_code;
    logic [20:0] target_uv;
    logic [16:0] slew_uv_per_us;
  } brc_setting_t;

  // One register access from the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } brc_access_t;

endpackage : brc_pkg

// [verilog/brc_i2c_slave.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Serial slave port: byte-level register access, MSB first
// ----------------------------------------------------------------------------
module brc_i2c_slave #(
  parameter logic [6:0] SLAVE_ADDR = 7'h60
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n,
  // Register side
  output brc_pkg::brc_access_t acc,
  input wire logic [7:0] rdata
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA, ST_ACK, ST_MACK}
    brc_state_t;

  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_q;
  logic sda_q;
  brc_state_t state;
  brc_state_t after_ack;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [7:0] ptr;
  logic rd_mode;
  logic ack_drive;

  // Three stage synchronisers; a change counts when stages two and three agree
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      if (scl_sync[1] == scl_sync[2])
        scl_q <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda_q <= sda_sync[2];
    end
  end

  wire logic scl_now = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;
  wire logic sda_now = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;
  wire logic scl_rise = scl_now & ~scl_q;
  wire logic scl_fall = ~scl_now & scl_q;
  wire logic start_c = scl_q & scl_now & sda_q & ~sda_now;
  wire logic stop_c = scl_q & scl_now & ~sda_q & sda_now;

  // Protocol state machine; data sampled on SCL rise, driven after fall
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      ptr <= 8'h00;
      rd_mode <= 1'b0;
      ack_drive <= 1'b0;
      acc <= '0;
    end
    else
    begin
      acc.wr <= 1'b0;
      acc.rd <= 1'b0;
      if (start_c)
      begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        ack_drive <= 1'b0;
      end
      else if (stop_c)
      begin
        state <= ST_IDLE;
        ack_drive <= 1'b0;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_REG, ST_WDATA:
            if (scl_rise)
            begin
              shreg <= {shreg[6:0], sda_now};
              bitcnt <= bitcnt + 4'h1;
            end
            else if (scl_fall && bitcnt == 4'h8)
            begin
              bitcnt <= 4'h0;
              state <= ST_ACK;
              if (state == ST_ADDR)
              begin
                ack_drive <= (shreg[7:1] == SLAVE_ADDR);
                rd_mode <= shreg[0];
                after_ack <= (shreg[7:1] != SLAVE_ADDR) ? ST_IDLE :
                             (shreg[0] ? ST_RDATA : ST_REG);
                if (shreg[7:1] == SLAVE_ADDR && shreg[0])
                begin
                  acc.addr <= ptr;
                end
              end
              else if (state == ST_REG)
              begin
                ack_drive <= 1'b1;
                ptr <= shreg;
                after_ack <= ST_WDATA;
              end
              else
              begin
                ack_drive <= 1'b1;
                acc.wr <= 1'b1;
                acc.addr <= ptr;
                acc.wdata <= shreg;
                ptr <= ptr + 8'h01;
                after_ack <= ST_WDATA;
              end
            end
          ST_ACK:
            if (scl_fall)
            begin
              ack_drive <= 1'b0;
              state <= after_ack;
              if (after_ack == ST_RDATA)
              begin
                // Read strobe marks the byte really loaded, so clear-on-read flags are seen first
                acc.rd <= 1'b1;
                shreg <= rdata;
                ack_drive <= ~rdata[7];
                bitcnt <= 4'h1;
              end
            end
          ST_RDATA:
            if (scl_fall)
            begin
              if (bitcnt == 4'h8)
              begin
                ack_drive <= 1'b0;
                bitcnt <= 4'h0;
                ptr <= ptr + 8'h01;
                state <= ST_MACK;
              end
              else
              begin
                ack_drive <= ~shreg[6];
                shreg <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          ST_MACK:
            if (scl_rise)
            begin
              state <= sda_now ? ST_IDLE : ST_ACK;
              after_ack <= ST_RDATA;
              acc.addr <= ptr;
            end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // Open drain: enable low while pulling SDA low
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      sda_oe_n <= 1'b1;
    else
      sda_oe_n <= ~ack_drive;
  end

endmodule : brc_i2c_slave

// [verilog/brc_setting_calc.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Converts register fields into target voltage and slew figures
// ----------------------------------------------------------------------------
module brc_setting_calc (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Selected fields
  input wire logic [6:0] voltage_code,
  input wire logic [2:0] slew_code,
  // Results
  output logic [20:0] target_uv,
  output logic [16:0] slew_uv_per_us
);

  // Top code reaches 1393750 uV, one bit past a 20-bit field
  localparam logic [20:0] BASE = 21'(brc_pkg::VOUT_BASE_UV);
  localparam logic [20:0] STEP = 21'(brc_pkg::VOUT_STEP_UV);
  localparam logic [16:0] FAST = 17'(brc_pkg::SLEW_FAST_UV_PER_US);

  // Registered so the long multiply never sits on the output path
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      target_uv <= 21'h000000;
      slew_uv_per_us <= 17'h00000;
    end
    else
    begin
      target_uv <= BASE + 21'(voltage_code) * STEP;
      slew_uv_per_us <= FAST >> slew_code;
    end
  end

endmodule : brc_setting_calc

// [verilog/brc_regs.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Regulator control register bank
// ----------------------------------------------------------------------------
module brc_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h60
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n,
  // Device pins
  input wire logic enable_pin,
  input wire logic voltage_select_pin,
  // Converter status
  input brc_pkg::brc_status_t status_in,
  // Converter settings
  output brc_pkg::brc_setting_t setting
);

  logic [7:0] voltage_setting_low;
  logic [7:0] voltage_setting_high;
  logic [7:0] regulator_control;
  logic reset_seen;
  logic [2:0] en_sync;
  logic [2:0] sel_sync;
  logic en_q;
  logic sel_q;
  logic [7:0] rdata;
  logic [20:0] target_uv;
  logic [16:0] slew_uv_per_us;
  brc_pkg::brc_access_t acc;
  brc_pkg::brc_status_t st;

  // --------------------------------------------------------------------------
  // Serial port and arithmetic
  // --------------------------------------------------------------------------
  brc_i2c_slave #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_port (
    .clock(clock),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_n(sda_oe_n),
    .acc(acc),
    .rdata(rdata)
  );

  wire logic soft_reset = acc.wr && acc.addr == brc_pkg::ADDR_CONTROL &&
                          acc.wdata[brc_pkg::CTRL_RESET_BIT];
  wire logic [7:0] sel_reg = sel_q ? voltage_setting_high : voltage_setting_low;

  brc_setting_calc u_calc (
    .clock(clock),
    .sys_rst(sys_rst),
    .voltage_code(sel_reg[6:0]),
    .slew_code(regulator_control[6:4]),
    .target_uv(target_uv),
    .slew_uv_per_us(slew_uv_per_us)
  );

  // --------------------------------------------------------------------------
  // Pin synchronisers, three stages with agreement filter
  // --------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      en_sync <= 3'h0;
      sel_sync <= 3'h0;
      en_q <= 1'b0;
      sel_q <= 1'b0;
      st <= '0;
    end
    else
    begin
      en_sync <= {en_sync[1:0], enable_pin};
      sel_sync <= {sel_sync[1:0], voltage_select_pin};
      if (en_sync[1] == en_sync[2])
        en_q <= en_sync[2];
      if (sel_sync[1] == sel_sync[2])
        sel_q <= sel_sync[2];
      st <= status_in;
    end
  end

  // --------------------------------------------------------------------------
  // Writable registers; soft reset restores defaults
  // --------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst || soft_reset)
    begin
      voltage_setting_low <= brc_pkg::VSET_RESET;
      voltage_setting_high <= brc_pkg::VSET_RESET;
      regulator_control <= brc_pkg::CTRL_RESET;
    end
    else if (acc.wr)
    begin
      case (acc.addr)
        brc_pkg::ADDR_VSET_LOW: voltage_setting_low <= acc.wdata;
        brc_pkg::ADDR_VSET_HIGH: voltage_setting_high <= acc.wdata;
        brc_pkg::ADDR_CONTROL: regulator_control <= acc.wdata & brc_pkg::CTRL_WMASK;
        default: ;
      endcase
    end
  end

  // Reset flag: the set wins over a clearing read in the same cycle
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      reset_seen <= 1'b0;
    else if (soft_reset)
      reset_seen <= 1'b1;
    else if (acc.rd && acc.addr == brc_pkg::ADDR_MONITOR)
      reset_seen <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Read mux; unmapped addresses return zero
  // --------------------------------------------------------------------------
  always_comb
  begin
    case (acc.addr)
      brc_pkg::ADDR_VSET_LOW: rdata = voltage_setting_low;
      brc_pkg::ADDR_VSET_HIGH: rdata = voltage_setting_high;
      brc_pkg::ADDR_CONTROL: rdata = regulator_control;
      brc_pkg::ADDR_ID_VENDOR: rdata = {brc_pkg::VENDOR_CODE, 1'b0, brc_pkg::CHIP_TYPE};
      brc_pkg::ADDR_ID_REV: rdata = {4'h0, brc_pkg::SILICON_REV};
      brc_pkg::ADDR_MONITOR:
        rdata = {st.soft_start_done & setting.regulator_on,
                 st.input_low_lockout_flag,
                 st.input_overvoltage_flag,
                 st.rising_transition_busy,
                 st.falling_transition_busy,
                 reset_seen,
                 st.thermal_trip_flag,
                 st.converter_active};
      default: rdata = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Settings driven to the converter
  // --------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      setting <= '0;
    else
    begin
      setting.regulator_on <= en_q & sel_reg[brc_pkg::VSET_EN_BIT];
      setting.discharge_on <= regulator_control[brc_pkg::CTRL_DISCH_BIT] &
                              ~(en_q & sel_reg[brc_pkg::VSET_EN_BIT]);
      setting.forced_pwm <= sel_q ? regulator_control[1] : regulator_control[0];
      setting.voltage_code <= sel_reg[6:0];
      setting.slew_code <= regulator_control[6:4];
      setting.target_uv <= target_uv;
      setting.slew_uv_per_us <= slew_uv_per_us;
    end
  end

endmodule : brc_regs

// [verification/brc_regs_asserts.sv]
`timescale 1ns/1ps
// --------------------------------------------------
// Port-level checks of the regulator register bank
// --------------------------------------------------
module brc_regs_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  // Device pins
  input wire logic enable_pin,
  input wire logic voltage_select_pin,
  // Converter status and settings
  input wire brc_pkg::brc_status_t status_in,
  input wire brc_pkg::brc_setting_t setting
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // Cycles since reset; settings lag the pins by synchroniser and calc stages
  logic [3:0] since_rst;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      since_rst <= 4'h0;
    else if (since_rst != 4'hF)
      since_rst <= since_rst + 4'h1;
  end

  property p_rst_clear;
    $fell(sys_rst) |-> setting == '0;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("settings not clear after reset");

  property p_rst_bus;
    $fell(sys_rst) |-> sda_oe_n;
  endproperty
  a_rst_bus: assert property (p_rst_bus)
    else $error("data line driven after reset");

  property p_off;
    (!enable_pin) [*8] |-> !setting.regulator_on;
  endproperty
  a_off: assert property (p_off)
    else $error("regulator on with enable pin low");

  property p_on_pin;
    $rose(setting.regulator_on) |-> enable_pin;
  endproperty
  a_on_pin: assert property (p_on_pin)
    else $error("regulator turned on without enable pin");

  property p_discharge;
    setting.discharge_on |-> !setting.regulator_on;
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("discharge while regulator on");

  property p_target;
    ((since_rst == 4'hF) && $stable(setting.voltage_code)) [*4] |->
      setting.target_uv == 21'h927C0 + 21'(setting.voltage_code) * 21'h186A;
  endproperty
  a_target: assert property (p_target)
    else $error("target voltage does not match code");

  property p_slew;
    ((since_rst == 4'hF) && $stable(setting.slew_code)) [*4] |->
      setting.slew_uv_per_us == (17'h0FA00 >> setting.slew_code);
  endproperty
  a_slew: assert property (p_slew)
    else $error("slew rate does not match code");

  property p_sda_hold;
    $changed(sda_oe_n) |-> !scl_in;
  endproperty
  a_sda_hold: assert property (p_sda_hold)
    else $error("data line moved while serial clock high");

endmodule : brc_regs_asserts

// [verification/brc_i2c_master_model.sv]
`timescale 1ns/1ps
// --------------------------------------------------
// Serial bus master: pulled-up data line, driven clock
// --------------------------------------------------
module brc_i2c_master_model #(
  parameter int HALF = 10
) (
  // Clock
  input wire logic clock,
  // Device pull-down, active low
  input wire logic sda_oe_n,
  // Bus lines
  output logic scl,
  output logic sda
);
  logic pull_low = 1'b0;
  logic [7:0] rx;
  logic ack;

  // Released line floats high through the pull-up, never keeps its last value
  assign sda = (pull_low || !sda_oe_n) ? 1'b0 : 1'b1;
  initial scl = 1'b1;

  task automatic half_bit();
    repeat (HALF) @(negedge clock);
  endtask : half_bit

  // Start (first 0, last 1) or stop (first 1, last 0) with clock high
  task automatic frame_edge(input logic first, input logic last);
    repeat (4) @(negedge clock);
    pull_low = first;
    half_bit();
    scl = 1'b1;
    half_bit();
    pull_low = last;
    half_bit();
    scl = !last;
  endtask : frame_edge

  // Data moves a few cycles after the clock falls, so it never looks like a frame edge
  task automatic one_bit(input logic b, output logic s);
    repeat (4) @(negedge clock);
    pull_low = !b;
    half_bit();
    scl = 1'b1;
    half_bit();
    s = sda;
    scl = 1'b0;
  endtask : one_bit

  // Byte then acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] got,
                      output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      one_bit(tx[i], got[i]);
    end
    one_bit(ack_bit, s);
    acked = !s;
  endtask : xfer

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] addr,
                           input logic [7:0] data, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    frame_edge(1'b0, 1'b1);
    xfer({dev, 1'b0}, 1'b1, rx, a0);
    xfer(addr, 1'b1, rx, a1);
    xfer(data, 1'b1, rx, a2);
    frame_edge(1'b1, 1'b0);
    ok = a0 && a1 && a2;
  endtask : write_reg

  // Pointer write, repeated start, one byte closed by a refusal
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] addr,
                          output logic [7:0] data, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    frame_edge(1'b0, 1'b1);
    xfer({dev, 1'b0}, 1'b1, rx, a0);
    xfer(addr, 1'b1, rx, a1);
    frame_edge(1'b0, 1'b1);
    xfer({dev, 1'b1}, 1'b1, rx, a2);
    xfer(8'hFF, 1'b1, data, ack);
    frame_edge(1'b1, 1'b0);
    ok = a0 && a1 && a2;
  endtask : read_reg

endmodule : brc_i2c_master_model

// [verification/tb_top.sv]
`timescale 1ns/1ps
// --------------------------------------------------
// Self-checking bench of the regulator register bank
// --------------------------------------------------
module tb_top;
  localparam logic [6:0] DEV = 7'h60;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic enable_pin = 1'b1;
  logic voltage_select_pin = 1'b0;
  brc_pkg::brc_status_t status_in = '0;
  brc_pkg::brc_setting_t setting;
  logic scl;
  logic sda;
  logic sda_oe_n;
  logic [7:0] rd;
  logic [7:0] ctl;
  logic [7:0] mon;
  logic ok;
  int mismatches = 0;
  int comparisons = 0;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  brc_regs #(.SLAVE_ADDR(DEV)) DUT (.clock(clock), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .sda_oe_n(sda_oe_n), .enable_pin(enable_pin),
    .voltage_select_pin(voltage_select_pin), .status_in(status_in), .setting(setting));

  brc_i2c_master_model #(.HALF(10)) M (.clock(clock), .sda_oe_n(sda_oe_n), .scl(scl),
    .sda(sda));

  task automatic check_reg(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_reg

  task automatic check_set(input string nm, input logic [20:0] exp, input logic [20:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_set

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    M.write_reg(DEV, a, d, ok);
    check_reg("write ack", 8'h01, {7'h0, ok});
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    M.read_reg(DEV, a, rd, ok);
    check_reg("read ack", 8'h01, {7'h0, ok});
    check_reg($sformatf("reg %h", a), exp, rd);
  endtask : rd_chk

  // Settings follow the pins through synchronisers and a calc stage
  task automatic settle();
    repeat (12) @(negedge clock);
  endtask : settle

  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial
  begin
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    settle();
    rd_chk(8'h00, brc_pkg::VSET_RESET);
    rd_chk(8'h02, brc_pkg::CTRL_RESET);
    rd_chk(8'h04, {4'h0, brc_pkg::SILICON_REV});
    wr(8'h03, 8'h00);
    rd_chk(8'h03, {brc_pkg::VENDOR_CODE, 1'b0, brc_pkg::CHIP_TYPE});
    $display("Test reset and identity done");
    wr(8'h00, 8'h00);
    wr(8'h01, 8'hFF);
    rd_chk(8'h01, 8'hFF);
    settle();
    check_set("on", 21'h0, {20'h0, setting.regulator_on});
    check_set("target", 21'h927C0, setting.target_uv);
    voltage_select_pin = 1'b1;
    settle();
    check_set("code", 21'h7F, {14'h0, setting.voltage_code});
    check_set("target", 21'h154456, setting.target_uv);
    check_set("on", 21'h1, {20'h0, setting.regulator_on});
    enable_pin = 1'b0;
    settle();
    check_set("on", 21'h0, {20'h0, setting.regulator_on});
    enable_pin = 1'b1;
    $display("Test voltage select done");
    for (int i = 0; i < 8; i++)
    begin
      ctl = {i[0], i[2:0], 2'b00, i[1:0]};
      wr(8'h02, ctl | 8'h08);
      rd_chk(8'h02, ctl);
      voltage_select_pin = 1'b0;
      settle();
      check_set("slew code", 21'(i), {18'h0, setting.slew_code});
      check_set("slew", 21'(17'h0FA00 >> i), {4'h0, setting.slew_uv_per_us});
      check_set("pwm", {20'h0, ctl[0]}, {20'h0, setting.forced_pwm});
      check_set("discharge", {20'h0, ctl[7]}, {20'h0, setting.discharge_on});
      voltage_select_pin = 1'b1;
      settle();
      check_set("pwm", {20'h0, ctl[1]}, {20'h0, setting.forced_pwm});
    end
    $display("Test control done");
    for (int k = 0; k < 7; k++)
    begin
      status_in = 7'(1 << k);
      mon = (k == 6) ? 8'h80 : 8'(1 << ((k >= 2) ? k + 1 : k));
      settle();
      rd_chk(8'h05, mon);
    end
    enable_pin = 1'b0;
    status_in = 7'h40;
    settle();
    rd_chk(8'h05, 8'h00);
    enable_pin = 1'b1;
    status_in = '0;
    $display("Test monitor done");
    wr(8'h02, 8'h04);
    rd_chk(8'h01, brc_pkg::VSET_RESET);
    rd_chk(8'h02, brc_pkg::CTRL_RESET);
    rd_chk(8'h05, 8'h04);
    rd_chk(8'h05, 8'h00);
    $display("Test soft reset done");
    M.write_reg(7'h61, 8'h00, 8'h11, ok);
    check_reg("foreign ack", 8'h00, {7'h0, ok});
    rd_chk(8'h00, brc_pkg::VSET_RESET);
    wr(8'h06, 8'h55);
    rd_chk(8'h06, 8'h00);
    $display("Test refusals done");
    print_verdict();
  end

  // Cut a hung run short
  initial
  begin
    repeat (100000) @(posedge clock);
    mismatches++;
    print_verdict();
  end

endmodule : tb_top

bind brc_regs brc_regs_asserts u_chk (.clock(clock), .sys_rst(sys_rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_oe_n(sda_oe_n), .enable_pin(enable_pin),
  .voltage_select_pin(voltage_select_pin), .status_in(status_in), .setting(setting));
